// [irq_mux_pkg.sv]
// Shared constants and types of the shared-vector interrupt multiplexer and trap selector
package irq_mux_pkg;
	localparam int unsigned VEC_COUNT = 4;
	localparam int unsigned SRC_COUNT = 8;
	// Register indices (word addresses on the register port)
	localparam logic [3:0] XVEC0_ENABLE_FLAG_OFS = 4'h0;
	localparam logic [3:0] XVEC1_ENABLE_FLAG_OFS = 4'h1;
	localparam logic [3:0] XVEC2_ENABLE_FLAG_OFS = 4'h2;
	localparam logic [3:0] XVEC3_ENABLE_FLAG_OFS = 4'h3;
	localparam logic [3:0] TRAP_FLAG_OFS = 4'h4;
	localparam logic [3:0] IRQ_STATUS_OFS = 4'h5;
	localparam logic [3:0] IRQ_MASK_OFS = 4'h6;
	localparam logic [3:0] TRAP_STATE_OFS = 4'h7;
	// Field positions of a select register
	localparam int unsigned ENABLE_LSB = 8;
	localparam int unsigned FLAG_LSB = 0;
	localparam logic [15:0] SELECT_RESET = 16'h0000;
	localparam logic [15:0] TRAP_FLAG_RESET = 16'h0000;
	localparam logic [3:0] IRQ_STATUS_RESET = 4'h0;
	localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
	// Trap flag register bit positions
	localparam int unsigned NMI_BIT = 15;
	localparam int unsigned STACK_OVER_BIT = 14;
	localparam int unsigned STACK_UNDER_BIT = 13;
	localparam int unsigned UNDEF_OPCODE_BIT = 7;
	localparam int unsigned MAC_INTR_BIT = 6;
	localparam int unsigned PROT_FAULT_BIT = 3;
	localparam int unsigned ILL_OPERAND_BIT = 2;
	localparam int unsigned ILL_INSTR_BIT = 1;
	localparam int unsigned ILL_BUS_BIT = 0;
	// Vectors, trap numbers, priority
	localparam logic [23:0] RESET_VECTOR = 24'h000000;
	localparam logic [23:0] NONMASKABLE_TRAP_VECTOR = 24'h000008;
	localparam logic [23:0] STACK_OVER_TRAP_VECTOR = 24'h000010;
	localparam logic [23:0] STACK_UNDER_TRAP_VECTOR = 24'h000018;
	localparam logic [23:0] CLASS_B_TRAP_VECTOR = 24'h000028;
	localparam logic [7:0] RESET_TRAP_NUM = 8'h00;
	localparam logic [7:0] NMI_TRAP_NUM = 8'h02;
	localparam logic [7:0] STACK_OVER_TRAP_NUM = 8'h04;
	localparam logic [7:0] STACK_UNDER_TRAP_NUM = 8'h06;
	localparam logic [7:0] CLASS_B_TRAP_NUM = 8'h0a;
	localparam logic [3:0] TOP_PRIORITY_LEVEL = 4'hf;

	// Priority tiers of exceptions
	typedef enum logic [1:0] {
		TIER_NONE,
		TIER_CLASS_B,
		TIER_CLASS_A,
		TIER_RESET
	} trap_tier_t;

	// Source events, one bit each
	typedef struct packed {
		logic first_can_node;
		logic second_can_node;
		logic twowire_rx;
		logic twowire_tx;
		logic twowire_err;
		logic second_sync_serial_rx;
		logic second_sync_serial_tx;
		logic second_sync_serial_err;
		logic second_async_serial_rx;
		logic second_async_serial_tx;
		logic second_async_serial_tbuf;
		logic second_async_serial_err;
		logic oscillator_watchdog_event;
		logic extra_pulse_unit;
	} src_events_t;

	// Hardware trap conditions
	typedef struct packed {
		logic nmi;
		logic stack_overflow_flag;
		logic stack_underflow_flag;
		logic undefined_opcode_flag;
		logic mac_interruption_flag;
		logic protected_instr_fault_flag;
		logic illegal_operand_access_flag;
		logic illegal_instr_access_flag;
		logic illegal_bus_access_flag;
	} trap_events_t;

	// Trap request toward the sequencer
	typedef struct packed {
		logic valid;
		trap_tier_t tier;
		logic [23:0] vector;
		logic [7:0] number;
	} trap_req_t;
endpackage : irq_mux_pkg

// [shared_vector_select_reg.sv]
// One shared vector: enable byte, sticky flag byte and request
`timescale 1ns/1ps
`default_nettype none
module shared_vector_select_reg #(
	parameter int unsigned SRCS = irq_mux_pkg::SRC_COUNT
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register access
	input wire logic wr_en,
	input wire logic [15:0] wr_data,
	output logic [15:0] value,
	// Sources and request
	input wire logic [SRCS-1:0] src_event,
	output logic request
);
	logic [SRCS-1:0] enable;
	logic [SRCS-1:0] flag;

	// One byte of enables and one byte of flags per register, nothing else fits
	if (SRCS != 8) begin : g_bad_srcs
		$error("shared_vector_select_reg: SRCS must be 8");
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			enable <= irq_mux_pkg::SELECT_RESET[irq_mux_pkg::ENABLE_LSB +: SRCS];
		end else if (wr_en) begin
			enable <= wr_data[irq_mux_pkg::ENABLE_LSB +: SRCS]; // [RULE2]
		end
	end

	// Flags record events regardless of enable; a write of zero clears, event wins
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag <= irq_mux_pkg::SELECT_RESET[irq_mux_pkg::FLAG_LSB +: SRCS];
		end else if (wr_en) begin
			flag <= (flag & wr_data[irq_mux_pkg::FLAG_LSB +: SRCS]) | src_event; // [RULE3] [RULE5] [RULE18]
		end else begin
			flag <= flag | src_event; // [RULE5] [RULE18]
		end
	end

	assign value = {enable, flag};
	assign request = |(flag & enable); // [RULE4] [RULE17]
endmodule : shared_vector_select_reg
`default_nettype wire

// [irq_mux_trap.sv]
// Shared peripheral vector multiplexer with hardware trap prioritiser
// How it works
// [RULE1] Four 16-bit select registers, one per shared vector.
// [RULE2] Upper byte of each select register holds per-source enables.
// [RULE3] Lower byte of each select register holds per-source flags.
// [RULE4] Only enabled sources can drive a request on their vector.
// [RULE5] Flags record events even while their enable is clear.
// [RULE6] Software reads flags to find which enabled source requested.
// [RULE7] The same structure is repeated for all four vectors.
// [RULE8] Two-wire, second serial rx/tx and tx-buffer route to vectors 0..2.
// [RULE9] Vector 3 takes errors, clock loss, both CAN and PWM; CAN/PWM also elsewhere.
// [RULE10] Resets vector to 000000h, trap number 00h, highest priority.
// [RULE11] NMI, stack over, stack under: own vectors 08h,10h,18h, numbers 02h,04h,06h.
// [RULE12] Class A traps sit at the second priority level.
// [RULE13] Class B traps share vector 28h, number 0Ah, lowest trap priority.
// [RULE14] Six class B conditions, each with its own flag.
// [RULE15] Priority level is forced to 15 while an exception is serviced.
// [RULE16] Traps preempt unless higher trap runs; interrupts cannot preempt traps. Here a trap of equal tier also waits.
// [RULE17] Vector request is OR of flag AND enable over sources.
// [RULE18] Event sets flag; it stays until software writes zero.
`timescale 1ns/1ps
`default_nettype none
module irq_mux_trap (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Peripheral events, one-cycle pulses
	input wire irq_mux_pkg::src_events_t src_events,
	// Shared vector requests
	output logic shared_vector_0,
	output logic shared_vector_1,
	output logic shared_vector_2,
	output logic shared_vector_3,
	// Reset and trap conditions
	input wire logic sw_reset_req,
	input wire logic watchdog_overflow,
	input wire irq_mux_pkg::trap_events_t trap_events,
	// Trap sequencer
	output irq_mux_pkg::trap_req_t trap_req,
	input wire logic trap_taken,
	input wire logic trap_done,
	input wire logic std_irq_req,
	output logic std_irq_allow,
	input wire logic [3:0] cpu_level_in,
	output logic [3:0] cpu_priority_level_field,
	// Summary interrupt
	output logic irq
);
	localparam int unsigned NV = irq_mux_pkg::VEC_COUNT;

	logic [NV-1:0][15:0] sel_value;
	logic [NV-1:0][7:0] sel_src;
	logic [NV-1:0] sel_req;
	logic [15:0] trap_flag;
	logic [3:0] irq_status;
	logic [3:0] irq_mask;
	logic reset_pending;
	irq_mux_pkg::trap_tier_t active_tier;
	irq_mux_pkg::trap_tier_t pend_tier;
	logic rst_seen;
	logic [3:0] next_irq_events;

	// Strobe and address are arguments so that continuous uses follow them
	function automatic logic wr_hit(input logic wr, input logic [3:0] addr, input logic [3:0] a);
		return wr && (addr == a);
	endfunction : wr_hit

	// Source routing per vector
	always_comb begin
		sel_src = '0;
		sel_src[0] = {src_events.first_can_node, // [RULE9]
			src_events.twowire_rx, src_events.twowire_tx, // [RULE8]
			src_events.second_sync_serial_rx, src_events.second_sync_serial_tx,
			src_events.second_async_serial_rx, src_events.second_async_serial_tx,
			src_events.second_async_serial_tbuf};
		sel_src[1] = {src_events.second_can_node, // [RULE9]
			src_events.twowire_rx, src_events.twowire_tx, // [RULE8]
			src_events.second_sync_serial_rx, src_events.second_sync_serial_tx,
			src_events.second_async_serial_rx, src_events.second_async_serial_tx,
			src_events.second_async_serial_tbuf};
		sel_src[2] = {src_events.extra_pulse_unit, // [RULE9]
			src_events.twowire_rx, src_events.twowire_tx, // [RULE8]
			src_events.second_sync_serial_rx, src_events.second_sync_serial_tx,
			src_events.second_async_serial_rx, src_events.second_async_serial_tx,
			src_events.second_async_serial_tbuf};
		sel_src[3] = {src_events.first_can_node, src_events.second_can_node, // [RULE9]
			src_events.twowire_err, src_events.second_sync_serial_err,
			src_events.second_async_serial_err, src_events.oscillator_watchdog_event,
			src_events.extra_pulse_unit, 1'b0};
	end

	genvar v;
	generate
		for (v = 0; v < NV; v++) begin : g_vec // [RULE1] [RULE7]
			shared_vector_select_reg #(
				.SRCS(irq_mux_pkg::SRC_COUNT)
			) u_sel (
				.core_clk(core_clk),
				.rst_n(rst_n),
				.wr_en(wr_hit(reg_wr, reg_addr, 4'(v))),
				.wr_data(reg_wdata),
				.value(sel_value[v]),
				.src_event(sel_src[v]),
				.request(sel_req[v])
			);
		end
	endgenerate

	assign shared_vector_0 = sel_req[0];
	assign shared_vector_1 = sel_req[1];
	assign shared_vector_2 = sel_req[2];
	assign shared_vector_3 = sel_req[3];

	// Trap flags: set by condition, cleared by writing zero, set wins
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			trap_flag <= irq_mux_pkg::TRAP_FLAG_RESET;
		end else begin
			trap_flag <= (wr_hit(reg_wr, reg_addr, irq_mux_pkg::TRAP_FLAG_OFS)
				? (trap_flag & reg_wdata) : trap_flag)
				| {trap_events.nmi, trap_events.stack_overflow_flag,
				trap_events.stack_underflow_flag, 5'h00,
				trap_events.undefined_opcode_flag, trap_events.mac_interruption_flag, 2'b00,
				trap_events.protected_instr_fault_flag, trap_events.illegal_operand_access_flag,
				trap_events.illegal_instr_access_flag, trap_events.illegal_bus_access_flag}; // [RULE14]
		end
	end

	// Reset requests: the hardware reset itself is pending from release
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_pending <= 1'b1;
		end else if (sw_reset_req || watchdog_overflow) begin
			reset_pending <= 1'b1;
		end else if (trap_taken && trap_req.tier == irq_mux_pkg::TIER_RESET) begin
			reset_pending <= 1'b0;
		end
	end

	// Highest pending tier and its vector
	always_comb begin
		trap_req = '0;
		pend_tier = irq_mux_pkg::TIER_NONE;
		if (reset_pending) begin
			pend_tier = irq_mux_pkg::TIER_RESET;
			trap_req.vector = irq_mux_pkg::RESET_VECTOR; // [RULE10]
			trap_req.number = irq_mux_pkg::RESET_TRAP_NUM;
		end else if (trap_flag[irq_mux_pkg::NMI_BIT]) begin
			pend_tier = irq_mux_pkg::TIER_CLASS_A; // [RULE12]
			trap_req.vector = irq_mux_pkg::NONMASKABLE_TRAP_VECTOR; // [RULE11]
			trap_req.number = irq_mux_pkg::NMI_TRAP_NUM;
		end else if (trap_flag[irq_mux_pkg::STACK_OVER_BIT]) begin
			pend_tier = irq_mux_pkg::TIER_CLASS_A;
			trap_req.vector = irq_mux_pkg::STACK_OVER_TRAP_VECTOR; // [RULE11]
			trap_req.number = irq_mux_pkg::STACK_OVER_TRAP_NUM;
		end else if (trap_flag[irq_mux_pkg::STACK_UNDER_BIT]) begin
			pend_tier = irq_mux_pkg::TIER_CLASS_A;
			trap_req.vector = irq_mux_pkg::STACK_UNDER_TRAP_VECTOR; // [RULE11]
			trap_req.number = irq_mux_pkg::STACK_UNDER_TRAP_NUM;
		end else if (|trap_flag[7:0]) begin
			pend_tier = irq_mux_pkg::TIER_CLASS_B;
			trap_req.vector = irq_mux_pkg::CLASS_B_TRAP_VECTOR; // [RULE13]
			trap_req.number = irq_mux_pkg::CLASS_B_TRAP_NUM;
		end
		trap_req.tier = pend_tier;
		// Only a strictly higher tier may preempt a trap in service
		trap_req.valid = (pend_tier != irq_mux_pkg::TIER_NONE)
			&& (pend_tier > active_tier); // [RULE16]
	end

	// Tier in service; a trap taken raises it, done returns to none
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			active_tier <= irq_mux_pkg::TIER_NONE;
		end else if (trap_taken && trap_req.valid) begin
			active_tier <= trap_req.tier;
		end else if (trap_done) begin
			active_tier <= irq_mux_pkg::TIER_NONE;
		end
	end

	assign std_irq_allow = std_irq_req && (active_tier == irq_mux_pkg::TIER_NONE); // [RULE16]
	assign cpu_priority_level_field = (active_tier != irq_mux_pkg::TIER_NONE)
		? irq_mux_pkg::TOP_PRIORITY_LEVEL : cpu_level_in; // [RULE15]

	// Summary interrupt: bit per tier entry plus shared-vector activity
	assign next_irq_events = {trap_taken && trap_req.valid && trap_req.tier == irq_mux_pkg::TIER_RESET,
		trap_taken && trap_req.valid && trap_req.tier == irq_mux_pkg::TIER_CLASS_A,
		trap_taken && trap_req.valid && trap_req.tier == irq_mux_pkg::TIER_CLASS_B,
		|sel_req};

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status <= irq_mux_pkg::IRQ_STATUS_RESET;
		end else if (wr_hit(reg_wr, reg_addr, irq_mux_pkg::IRQ_STATUS_OFS)) begin
			irq_status <= (irq_status & ~reg_wdata[3:0]) | next_irq_events;
		end else begin
			irq_status <= irq_status | next_irq_events;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask <= irq_mux_pkg::IRQ_MASK_RESET;
		end else if (wr_hit(reg_wr, reg_addr, irq_mux_pkg::IRQ_MASK_OFS)) begin
			irq_mask <= reg_wdata[3:0];
		end
	end

	assign irq = |(irq_status & irq_mask);

	// Delayed copy of the pending reset, readable by software in the state word
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_seen <= 1'b0;
		end else begin
			rst_seen <= reset_pending;
		end
	end

	// Read data one cycle after the strobe
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				irq_mux_pkg::XVEC0_ENABLE_FLAG_OFS: reg_rdata <= sel_value[0]; // [RULE6]
				irq_mux_pkg::XVEC1_ENABLE_FLAG_OFS: reg_rdata <= sel_value[1];
				irq_mux_pkg::XVEC2_ENABLE_FLAG_OFS: reg_rdata <= sel_value[2];
				irq_mux_pkg::XVEC3_ENABLE_FLAG_OFS: reg_rdata <= sel_value[3];
				irq_mux_pkg::TRAP_FLAG_OFS: reg_rdata <= trap_flag;
				irq_mux_pkg::IRQ_STATUS_OFS: reg_rdata <= {12'h000, irq_status};
				irq_mux_pkg::IRQ_MASK_OFS: reg_rdata <= {12'h000, irq_mask};
				irq_mux_pkg::TRAP_STATE_OFS: reg_rdata <= {13'h0, rst_seen, active_tier};
				default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end
endmodule : irq_mux_trap
`default_nettype wire

// [irq_mux_trap_monitor.sv]
// Concurrent checks on the shared vector multiplexer and trap selector ports
`timescale 1ns/1ps
`default_nettype none
module irq_mux_trap_monitor (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register and events
	input wire logic [3:0] reg_addr,
	input wire logic reg_wr,
	input wire irq_mux_pkg::src_events_t src_events,
	input wire logic shared_vector_0,
	input wire logic shared_vector_3,
	// Trap side
	input wire irq_mux_pkg::trap_req_t trap_req,
	input wire logic trap_taken,
	input wire logic std_irq_req,
	input wire logic std_irq_allow,
	input wire logic [3:0] cpu_priority_level_field
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_level_forced: assert property (
		std_irq_req && !std_irq_allow |-> cpu_priority_level_field == 4'hf) else $error("level");
	a_allow_gated: assert property (
		std_irq_allow |-> std_irq_req) else $error("allow without request");
	a_taken_blocks: assert property (
		trap_taken && trap_req.valid |=> !std_irq_allow) else $error("irq during trap");
	a_reset_vector: assert property (
		trap_req.valid && trap_req.tier == irq_mux_pkg::TIER_RESET
		|-> trap_req.vector == 24'h000000 && trap_req.number == 8'h00) else $error("reset vec");
	a_class_a_vec: assert property (
		trap_req.valid && trap_req.tier == irq_mux_pkg::TIER_CLASS_A
		|-> trap_req.vector == {14'h0, trap_req.number, 2'b00}) else $error("class a vec");
	a_class_b_vec: assert property (
		trap_req.valid && trap_req.tier == irq_mux_pkg::TIER_CLASS_B
		|-> trap_req.vector == 24'h000028 && trap_req.number == 8'h0a) else $error("class b vec");
	a_flag_sticky: assert property (
		$fell(shared_vector_3) |-> $past(reg_wr) && $past(reg_addr) == 4'h3) else $error("flag lost");
	a_vec_cause: assert property (
		$rose(shared_vector_0) |-> $past(reg_wr) || $past(|src_events)) else $error("stray request");
	a_take_drops: assert property (
		trap_taken && trap_req.valid |=> !trap_req.valid || trap_req.tier > $past(trap_req.tier))
		else $error("request not dropped");
endmodule : irq_mux_trap_monitor
bind irq_mux_trap irq_mux_trap_monitor u_mon (.core_clk, .rst_n, .reg_addr, .reg_wr, .src_events,
	.shared_vector_0, .shared_vector_3, .trap_req, .trap_taken, .std_irq_req, .std_irq_allow,
	.cpu_priority_level_field);
`default_nettype wire

// [cpu_trap_seq_model.sv]
// Trap sequencer stand-in: accepts a request after a set wait, ends service later
`timescale 1ns/1ps
`default_nettype none
module cpu_trap_seq_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Pace
	input wire logic [3:0] lat,
	input wire logic [3:0] svc,
	// Handshake
	input wire irq_mux_pkg::trap_req_t trap_req,
	output logic trap_taken,
	output logic trap_done
);
	int wait_cnt;
	int svc_cnt;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_cnt <= 0;
			svc_cnt <= 0;
			trap_taken <= 1'b0;
			trap_done <= 1'b0;
		end else begin
			trap_taken <= 1'b0;
			trap_done <= 1'b0;
			if (trap_req.valid && !trap_taken && wait_cnt >= lat) begin
				trap_taken <= 1'b1;
				wait_cnt <= 0;
				svc_cnt <= svc;
			end else begin
				wait_cnt <= trap_req.valid ? wait_cnt + 1 : 0;
				svc_cnt <= (svc_cnt != 0) ? svc_cnt - 1 : 0;
				trap_done <= (svc_cnt == 1);
			end
		end
	end
endmodule : cpu_trap_seq_model
`default_nettype wire

// [irq_mux_trap_tb_top.sv]
// Self-checking bench of the shared vector multiplexer and trap selector
`timescale 1ns/1ps
`default_nettype none
module irq_mux_trap_tb_top;
	logic core_clk = 0;
	logic rst_n = 0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic [15:0] reg_rdata;
	irq_mux_pkg::src_events_t src_events = '0;
	irq_mux_pkg::trap_events_t trap_events = '0;
	irq_mux_pkg::trap_req_t trap_req;
	logic sv0, sv1, sv2, sv3, trap_taken, trap_done, allow, irq;
	logic sw_reset_req = 0;
	logic watchdog_overflow = 0;
	logic std_irq_req = 1;
	logic [3:0] cpu_level_in = 4'h3;
	logic [3:0] level, lat = 4'h2, svc = 4'h8;
	int num_errors = 0;
	int samples_checked = 0;
	int en[4], fl[4];
	int mp[4][8] = '{'{3, 4, 5, 7, 8, 10, 11, 13}, '{3, 4, 5, 7, 8, 10, 11, 12},
		'{3, 4, 5, 7, 8, 10, 11, 0}, '{-1, 0, 1, 2, 6, 9, 12, 13}};
	int fp[9] = '{15, 14, 13, 7, 6, 3, 2, 1, 0};
	logic [15:0] d;
	logic [31:0] r;
	logic seen_req = 1'b0;
	always #2.5 core_clk = ~core_clk;
	irq_mux_trap u_dut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.src_events, .shared_vector_0(sv0), .shared_vector_1(sv1), .shared_vector_2(sv2),
		.shared_vector_3(sv3), .sw_reset_req, .watchdog_overflow, .trap_events, .trap_req,
		.trap_taken, .trap_done, .std_irq_req, .std_irq_allow(allow), .cpu_level_in,
		.cpu_priority_level_field(level), .irq);
	cpu_trap_seq_model u_cpu (.core_clk, .rst_n, .lat, .svc, .trap_req, .trap_taken, .trap_done);
	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
		chk(d, exp);
	endtask : rdc
	task automatic pulse(input logic [13:0] s, input logic [8:0] t);
		@(posedge core_clk);
		src_events <= s;
		trap_events <= t;
		@(posedge core_clk);
		src_events <= '0;
		trap_events <= '0;
		@(negedge core_clk);
	endtask : pulse
	task automatic wfor(input bit done);
		for (int i = 0; i < 60 && !(done ? trap_done : trap_taken); i++) @(negedge core_clk);
		chk(done ? trap_done : trap_taken, 1);
		@(negedge core_clk);
	endtask : wfor
	task automatic check_all();
		for (int v = 0; v < 4; v++) begin
			rdc(v[3:0], {en[v][7:0], fl[v][7:0]});
			r[v] = |(en[v] & fl[v]);
		end
		seen_req = seen_req | (|r[3:0]);
		chk({sv3, sv2, sv1, sv0}, r[3:0]);
	endtask : check_all
	task automatic end_sim();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim
	initial begin
		#100000;
		num_errors++;
		end_sim();
	end
	initial begin
		void'($urandom(59));
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		@(negedge core_clk);
		chk({trap_req.valid, trap_req.vector, trap_req.number}, {1'b1, 32'h0});
		wfor(0);
		chk({level, allow}, {4'hf, 1'b0});
		wfor(1);
		chk({level, allow}, {cpu_level_in, 1'b1});
		for (int k = 0; k < 12; k++) begin
			for (int v = 0; v < 4; v++) begin
				en[v] = $urandom % 256;
				fl[v] = 0;
				wr(v[3:0], {en[v][7:0], 8'h00});
			end
			r = $urandom;
			pulse(r[13:0], 9'h000);
			for (int v = 0; v < 4; v++)
				for (int b = 0; b < 8; b++)
					if (mp[v][b] >= 0 && r[mp[v][b]]) fl[v] |= 1 << b;
			check_all();
			r = $urandom;
			for (int v = 0; v < 4; v++) begin
				fl[v] &= r[8*v +: 8];
				wr(v[3:0], {en[v][7:0], r[8*v +: 8]});
			end
			check_all();
		end
		wr(4'h9, 16'hffff);
		rdc(4'h9, 16'h0000);
		lat <= 4'h1;
		for (int i = 0; i < 9; i++) begin
			pulse(14'h0, 9'h100 >> i);
			r = (i < 3) ? {8'(8 * (i + 1)), 8'(2 * (i + 1))} : 32'h280a;
			chk({trap_req.valid, trap_req.vector[15:0], trap_req.number}, {1'b1, r[23:0]});
			rdc(4'h4, 16'h1 << fp[i]);
			wfor(0);
			chk(level, 4'hf);
			wr(4'h4, 16'h0000);
			wfor(1);
			chk(trap_req.valid, 1'b0);
		end
		lat <= 4'hf;
		pulse(14'h0, 9'h1ff);
		chk(trap_req.number, 8'h02);
		wr(4'h4, 16'h7fff);
		@(negedge core_clk);
		chk(trap_req.number, 8'h04);
		wr(4'h4, 16'h3fff);
		@(negedge core_clk);
		chk(trap_req.number, 8'h06);
		wr(4'h4, 16'h00ff);
		@(negedge core_clk);
		chk(trap_req.number, 8'h0a);
		lat <= 4'h1;
		wfor(0);
		pulse(14'h0, 9'h100);
		chk({trap_req.valid, trap_req.number, allow}, {1'b1, 8'h02, 1'b0});
		wfor(0);
		wr(4'h4, 16'h0000);
		wfor(1);
		for (int v = 0; v < 4; v++) wr(v[3:0], 16'h0000);
		rdc(4'h5, {12'h000, 3'b111, seen_req});
		wr(4'h5, 16'h000f);
		rdc(4'h5, 16'h0000);
		wr(4'h6, 16'h0001);
		wr(4'h0, 16'h0100);
		pulse(14'h0008, 9'h000);
		@(negedge core_clk);
		chk({sv0, irq}, 2'b11);
		wr(4'h6, 16'h0000);
		@(negedge core_clk);
		chk(irq, 1'b0);
		for (int j = 0; j < 2; j++) begin
			@(posedge core_clk);
			watchdog_overflow <= (j == 0);
			sw_reset_req <= (j == 1);
			@(posedge core_clk);
			watchdog_overflow <= 1'b0;
			sw_reset_req <= 1'b0;
			@(negedge core_clk);
			chk({trap_req.valid, trap_req.tier, trap_req.vector, trap_req.number},
				{1'b1, irq_mux_pkg::TIER_RESET, 24'h000000, 8'h00});
			wfor(0);
			chk(level, 4'hf);
			wfor(1);
		end
		@(posedge core_clk);
		std_irq_req <= 1'b0;
		@(negedge core_clk);
		chk(allow, 1'b0);
		end_sim();
	end
endmodule : irq_mux_trap_tb_top
`default_nettype wire
